/* File: rtl/deac_core.sv */
/*
 data store access control: pointer banks, store control and power flag
 registers, internal ram routing, external move decode and page programming.
 assumes the cpu core gives one request per cycle, synchronous to clk_i,
 and supply_ok_i comes from a supply monitor already synchronous to clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
`include "deac_cfg.svh"
module deac_core
    import deac_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = `DEAC_PROG_CYCLES,
    parameter int AW = `DEAC_STORE_AW,
    parameter int PAGE = `DEAC_PAGE_BYTES,
    parameter int IW = `DEAC_PAGE_IW
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic npor_i,
    input wire logic supply_ok_i,
    input wire logic int_req_i,
    input wire logic int_wr_i,
    input wire logic int_indirect_i,
    input wire logic [7:0] int_addr_i,
    input wire logic [7:0] int_wdata_i,
    output logic [7:0] int_rdata_o,
    input wire logic xm_req_i,
    input wire logic xm_wr_i,
    input wire logic [7:0] xm_wdata_i,
    output logic xm_ack_o,
    output logic [7:0] xm_rdata_o,
    output logic ext_req_o,
    output logic ext_wr_o,
    output logic [15:0] ext_addr_o,
    output logic [7:0] ext_wdata_o,
    output logic busy_o
);
    // register state
    logic [15:0] ptr0_q, ptr0_d, ptr1_q, ptr1_d;
    logic ld_q, ld_d, we_q, we_d, en_q, en_d, dps_q, dps_d;
    logic pof_q, pof_d;
    logic [AW-IW-1:0] page_q, page_d;
    logic [7:0] last_q, last_d;
    logic [7:0] int_rd_q, int_rd_d, xm_rd_q, xm_rd_d;
    logic xm_ack_q, ext_req_q, ext_req_d, ext_wr_q, ext_wr_d, busy_q;
    logic [15:0] ext_addr_q, ext_addr_d;
    logic [7:0] ext_wd_q, ext_wd_d;
    // memories
    logic [7:0] ram_q [256];
    logic [7:0] store_q [2**AW];
    // decode and sequencer wires
    logic sfr_acc, sfr_wr, ram_wr, onchip, st_wr, st_ld, st_go, busy, done;
    logic [15:0] act_ptr;
    logic [7:0] ctl_rd;
    logic [PAGE*8-1:0] buf_data;
    logic [PAGE-1:0] buf_vld;

    // active pointer selection
    always_comb begin
        act_ptr = dps_q ? ptr1_q : ptr0_q; // [RULE2]
    end

    // address space routing
    always_comb begin
        sfr_acc = int_req_i && int_addr_i[7] && !int_indirect_i; // [RULE5]
        sfr_wr = sfr_acc && int_wr_i;
        ram_wr = int_req_i && int_wr_i && !sfr_acc; // [RULE6]
        onchip = en_q && (act_ptr < `DEAC_STORE_LIMIT); // [RULE7]
        st_wr = xm_req_i && xm_wr_i && onchip;
        st_ld = st_wr && we_q && supply_ok_i && !busy; // [RULE9]
        st_go = st_ld && !ld_q; // [RULE12] [RULE13]
    end

    // store control readback with live hardware flags
    always_comb begin
        ctl_rd = '0;
        ctl_rd[`DEAC_BIT_LD] = ld_q;
        ctl_rd[`DEAC_BIT_WE] = we_q;
        ctl_rd[`DEAC_BIT_EN] = en_q;
        ctl_rd[`DEAC_BIT_DPS] = dps_q;
        ctl_rd[`DEAC_BIT_RDY] = !busy; // [RULE11]
        ctl_rd[`DEAC_BIT_INH] = supply_ok_i; // [RULE15]
    end

    // special register writes and internal read data
    always_comb begin
        ptr0_d = ptr0_q;
        ptr1_d = ptr1_q;
        ld_d = ld_q;
        we_d = we_q;
        en_d = en_q;
        dps_d = dps_q;
        pof_d = pof_q;
        int_rd_d = int_rd_q;
        if (sfr_wr) begin
            case (int_addr_i)
                `DEAC_SFR_PTR0_LO: ptr0_d[7:0] = int_wdata_i; // [RULE1]
                `DEAC_SFR_PTR0_HI: ptr0_d[15:8] = int_wdata_i; // [RULE1]
                `DEAC_SFR_PTR1_LO: ptr1_d[7:0] = int_wdata_i; // [RULE1]
                `DEAC_SFR_PTR1_HI: ptr1_d[15:8] = int_wdata_i; // [RULE1]
                `DEAC_SFR_PWR: pof_d = int_wdata_i[`DEAC_BIT_POF]; // [RULE4]
                `DEAC_SFR_STORE: begin
                    ld_d = int_wdata_i[`DEAC_BIT_LD];
                    we_d = int_wdata_i[`DEAC_BIT_WE];
                    en_d = int_wdata_i[`DEAC_BIT_EN];
                    dps_d = int_wdata_i[`DEAC_BIT_DPS];
                end
                default: begin
                end
            endcase
        end
        if (int_req_i && !int_wr_i) begin
            if (sfr_acc) begin
                case (int_addr_i)
                    `DEAC_SFR_PTR0_LO: int_rd_d = ptr0_q[7:0];
                    `DEAC_SFR_PTR0_HI: int_rd_d = ptr0_q[15:8];
                    `DEAC_SFR_PTR1_LO: int_rd_d = ptr1_q[7:0];
                    `DEAC_SFR_PTR1_HI: int_rd_d = ptr1_q[15:8];
                    `DEAC_SFR_PWR: int_rd_d = {3'h0, pof_q, 4'h0};
                    `DEAC_SFR_STORE: int_rd_d = ctl_rd;
                    default: int_rd_d = 8'h00;
                endcase
            end else begin
                int_rd_d = ram_q[int_addr_i]; // [RULE6]
            end
        end
    end

    // external move decode, store reads and programming bookkeeping
    always_comb begin
        ext_req_d = 1'b0;
        ext_wr_d = ext_wr_q;
        ext_addr_d = ext_addr_q;
        ext_wd_d = ext_wd_q;
        xm_rd_d = xm_rd_q;
        page_d = page_q;
        last_d = last_q;
        if (xm_req_i && !onchip) begin
            ext_req_d = 1'b1; // [RULE7]
            ext_wr_d = xm_wr_i;
            ext_addr_d = act_ptr;
            ext_wd_d = xm_wdata_i;
        end
        if (xm_req_i && !xm_wr_i && onchip) begin
            if (busy) begin
                xm_rd_d = {~last_q[7], last_q[6:0]}; // [RULE14]
            end else begin
                xm_rd_d = store_q[act_ptr[AW-1:0]];
            end
        end
        if (st_go) begin
            page_d = act_ptr[AW-1:IW]; // [RULE16]
            last_d = xm_wdata_i;
        end
    end

    // control registers
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ptr0_q <= `DEAC_PTR_RST;
            ptr1_q <= `DEAC_PTR_RST;
            ld_q <= `DEAC_CTL_RST;
            we_q <= `DEAC_CTL_RST;
            en_q <= `DEAC_CTL_RST;
            dps_q <= `DEAC_CTL_RST;
            page_q <= '0;
            last_q <= 8'h00;
            int_rd_q <= 8'h00;
            xm_rd_q <= 8'h00;
            xm_ack_q <= 1'b0;
            ext_req_q <= 1'b0;
            ext_wr_q <= 1'b0;
            ext_addr_q <= 16'h0000;
            ext_wd_q <= 8'h00;
            busy_q <= 1'b0;
        end else begin
            ptr0_q <= ptr0_d;
            ptr1_q <= ptr1_d;
            ld_q <= ld_d;
            we_q <= we_d;
            en_q <= en_d;
            dps_q <= dps_d;
            page_q <= page_d;
            last_q <= last_d;
            int_rd_q <= int_rd_d;
            xm_rd_q <= xm_rd_d;
            xm_ack_q <= xm_req_i;
            ext_req_q <= ext_req_d;
            ext_wr_q <= ext_wr_d;
            ext_addr_q <= ext_addr_d;
            ext_wd_q <= ext_wd_d;
            busy_q <= busy;
        end
    end

    // power loss flag lives on the power-on reset only
    always_ff @(posedge clk_i or negedge npor_i) begin
        if (!npor_i) begin
            pof_q <= `DEAC_POF_PWRUP; // [RULE4]
        end else begin
            pof_q <= pof_d;
        end
    end

    // internal ram, lower and upper halves
    always_ff @(posedge clk_i) begin
        if (ram_wr) begin
            ram_q[int_addr_i] <= int_wdata_i;
        end
    end

    // cell array: only slots marked valid in the buffer are rewritten
    always_ff @(posedge clk_i) begin
        if (done) begin
            for (int i = 0; i < PAGE; i++) begin
                if (buf_vld[i]) begin
                    store_q[{page_q, IW'(i)}] <= buf_data[i*8 +: 8]; // [RULE8] [RULE13]
                end
            end
        end
    end

    // write buffer, emptied after every cycle or abort
    deac_page_buf #(.DEPTH(PAGE), .IW(IW)) u_buf (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .ld_i(st_ld),
        .idx_i(act_ptr[IW-1:0]),
        .data_i(xm_wdata_i),
        .clr_i(done || (busy && !supply_ok_i)),
        .data_o(buf_data),
        .valid_o(buf_vld)
    );

    // self-timed programming
    deac_prog_timer #(.PROG_CYCLES(PROG_CYCLES)) u_tmr (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .start_i(st_go),
        .abort_i(!supply_ok_i),
        .busy_o(busy),
        .done_o(done)
    );

    assign int_rdata_o = int_rd_q;
    assign xm_ack_o = xm_ack_q;
    assign xm_rdata_o = xm_rd_q;
    assign ext_req_o = ext_req_q;
    assign ext_wr_o = ext_wr_q;
    assign ext_addr_o = ext_addr_q;
    assign ext_wdata_o = ext_wd_q;
    assign busy_o = busy_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    a_ptr_select: assert property ( // [RULE2]
        xm_req_i && !onchip |=> ext_req_o && ext_addr_o == $past(dps_q ? ptr1_q : ptr0_q)
    ) else $error("external address not from selected pointer");
    a_pof_write: assert property ( // [RULE4]
        sfr_wr && int_addr_i == `DEAC_SFR_PWR |=> pof_q == $past(int_wdata_i[4])
    ) else $error("power loss flag not written");
    a_sfr_direct: assert property ( // [RULE5]
        int_req_i && !int_wr_i && !int_indirect_i && int_addr_i == `DEAC_SFR_STORE
        |=> int_rdata_o[5:2] == {ld_q, we_q, en_q, dps_q}
    ) else $error("direct read missed store control");
    a_ram_indirect: assert property ( // [RULE6]
        int_req_i && int_wr_i && int_indirect_i |=> $stable({ptr0_q, ptr1_q, ld_q, we_q, en_q})
    ) else $error("indirect write reached special registers");
    a_onchip_route: assert property ( // [RULE7]
        xm_req_i && onchip |=> !ext_req_o
    ) else $error("on-chip move went external");
    a_we_needed: assert property ( // [RULE9]
        $rose(busy) |-> $past(we_q && supply_ok_i)
    ) else $error("programming started without write enable");
    a_load_only: assert property ( // [RULE12]
        !busy && ld_q |=> !busy
    ) else $error("page load started programming");
    a_busy_flag: assert property ( // [RULE11]
        st_go |=> busy ##0 !ctl_rd[1]
    ) else $error("ready flag not cleared by programming");
    a_busy_read: assert property ( // [RULE14]
        busy && xm_req_i && !xm_wr_i && onchip |=> xm_rdata_o == {~last_q[7], last_q[6:0]}
    ) else $error("busy read not msb inverted");
    a_low_abort: assert property ( // [RULE15]
        !supply_ok_i |=> !busy
    ) else $error("programming ran on low supply");

    c_page_prog: cover property (ld_q && st_ld ##[1:20] st_go);
    c_byte_done: cover property (st_go ##[1:1000] done);
    c_abort: cover property (busy && !supply_ok_i);
    c_ext_move: cover property (xm_req_i && !onchip && xm_wr_i);
endmodule // deac_core
`default_nettype wire

/* File: rtl/deac_cfg.svh */
/*
 constants for the data store access block: special register offsets,
 field positions, reset values and programming time.
 assumes a 20 MHz system clock shared with the cpu core.
*/
// What this block does
// RULE1 - two 16-bit pointer banks at special registers 82H-83H and 84H-85H
// RULE2 - bit 2 of store control picks bank zero when 0, bank one when 1
// RULE3 - software sets the pointer select bit before using the active pointer
// RULE4 - power loss flag set at power-up, software writable, kept through reset
// RULE5 - direct accesses above 7FH reach special registers, not upper ram
// RULE6 - indirect accesses above 7FH, stack included, reach the upper ram bytes
// RULE7 - store enable set and pointer below 2K selects on-chip store, else external
// RULE8 - a byte write rewrites only the addressed store byte
// RULE9 - store writes happen only while write enable bit 4 is set
// RULE10 - each programming cycle is self-timed, typically 4 ms
// RULE11 - ready flag bit 1 is low while programming runs, high when done
// RULE12 - with page load bit 5 set a write only fills the buffer
// RULE13 - final write with page load clear programs all buffered bytes of its page
// RULE14 - reads during programming return the written byte with msb inverted
// RULE15 - inhibit flag bit 0 low on low supply aborts and blocks programming
// RULE16 - page is address bits 10 to 5, byte in buffer bits 4 to 0
// RULE17 - buffer entries are marked empty once a programming cycle ends
`ifndef DEAC_CFG_SVH
`define DEAC_CFG_SVH

// special register offsets
`define DEAC_SFR_PTR0_LO 8'h82
`define DEAC_SFR_PTR0_HI 8'h83
`define DEAC_SFR_PTR1_LO 8'h84
`define DEAC_SFR_PTR1_HI 8'h85
`define DEAC_SFR_PWR 8'h87
`define DEAC_SFR_STORE 8'h96

// store control fields and the power loss flag bit
`define DEAC_BIT_INH 0
`define DEAC_BIT_RDY 1
`define DEAC_BIT_DPS 2
`define DEAC_BIT_EN 3
`define DEAC_BIT_WE 4
`define DEAC_BIT_LD 5
`define DEAC_BIT_POF 4

// reset values
`define DEAC_PTR_RST 16'h0000
`define DEAC_CTL_RST 1'b0
`define DEAC_POF_PWRUP 1'b1

// store geometry
`define DEAC_STORE_LIMIT 16'h0800
`define DEAC_STORE_AW 11
`define DEAC_PAGE_BYTES 32
`define DEAC_PAGE_IW 5

// programming time
`define DEAC_PROG_TIME_US 4000
`define DEAC_CLK_MHZ 20
`define DEAC_PROG_CYCLES (`DEAC_PROG_TIME_US * `DEAC_CLK_MHZ)

`endif

/* File: rtl/deac_pkg.sv */
/*
 types shared by the data store access modules.
 assumes deac_cfg.svh holds the numeric constants.
*/
package deac_pkg;
    // programming sequencer states, one-hot
    typedef enum logic [1:0] {
        DEAC_ST_IDLE = 2'b01,
        DEAC_ST_PROG = 2'b10
    } deac_prog_st_t;
endpackage

/* File: rtl/deac_prog_timer.sv */
/*
 self-timed programming sequencer: counts the cell programming time.
 assumes start is a single-cycle request and abort a level held for as long as the supply is low.
*/
`timescale 1ns/10ps
`default_nettype none
`include "deac_cfg.svh"
module deac_prog_timer
    import deac_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = `DEAC_PROG_CYCLES
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic start_i,
    input wire logic abort_i,
    output logic busy_o,
    output logic done_o
);
    localparam int CW = $clog2(PROG_CYCLES + 1);
    deac_prog_st_t st_q, st_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic done_q, done_d;

    // next state: count down, finish at zero, abort on low supply
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        done_d = 1'b0;
        case (st_q)
            DEAC_ST_IDLE: begin
                if (start_i && !abort_i) begin
                    st_d = DEAC_ST_PROG;
                    cnt_d = CW'(PROG_CYCLES - 1);
                end
            end
            DEAC_ST_PROG: begin
                if (abort_i) begin
                    st_d = DEAC_ST_IDLE; // [RULE15]
                end else if (cnt_q == '0) begin
                    st_d = DEAC_ST_IDLE; // [RULE10]
                    done_d = 1'b1;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: begin
                st_d = DEAC_ST_IDLE;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q <= DEAC_ST_IDLE;
            cnt_q <= '0;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            done_q <= done_d;
        end
    end

    // busy covers the commit cycle too, so ready never shows before the cells hold the data
    assign busy_o = (st_q == DEAC_ST_PROG) || done_q;
    assign done_o = done_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    a_prog_holds: assert property ( // [RULE10]
        busy_o && !abort_i && cnt_q != '0 |=> busy_o
    ) else $error("programming ended before its time");
    a_prog_finish: assert property ( // [RULE11]
        st_q == DEAC_ST_PROG && !abort_i && cnt_q == '0 |=> done_o ##1 !busy_o
    ) else $error("programming did not finish at count zero");
endmodule // deac_prog_timer
`default_nettype wire

/* File: rtl/deac_page_buf.sv */
/*
 volatile page write buffer: one byte and one valid mark per page slot.
 assumes load and clear never come in the same cycle.
*/
`timescale 1ns/10ps
`default_nettype none
`include "deac_cfg.svh"
module deac_page_buf
    import deac_pkg::*;
#(
    parameter int DEPTH = `DEAC_PAGE_BYTES,
    parameter int IW = `DEAC_PAGE_IW
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ld_i,
    input wire logic [IW-1:0] idx_i,
    input wire logic [7:0] data_i,
    input wire logic clr_i,
    output logic [DEPTH*8-1:0] data_o,
    output logic [DEPTH-1:0] valid_o
);
    logic [7:0] buf_q [DEPTH];
    logic [DEPTH-1:0] vld_q, vld_d;

    // valid marks: set by a load, all dropped by a clear
    always_comb begin
        vld_d = vld_q;
        if (clr_i) begin
            vld_d = '0; // [RULE17]
        end
        if (ld_i) begin
            vld_d[idx_i] = 1'b1; // [RULE12]
        end
    end

    // valid registers
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            vld_q <= '0;
        end else begin
            vld_q <= vld_d;
        end
    end

    // byte storage
    always_ff @(posedge clk_i) begin
        if (ld_i) begin
            buf_q[idx_i] <= data_i;
        end
    end

    // flatten for the commit logic
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            data_o[i*8 +: 8] = buf_q[i];
        end
    end
    assign valid_o = vld_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    a_buf_cleared: assert property ( // [RULE17]
        clr_i && !ld_i |=> valid_o == '0
    ) else $error("buffer not empty after clear");
endmodule // deac_page_buf
`default_nettype wire

/* File: tb/deac_cpu_model.sv */
/*
 cpu core model: drives internal data accesses and external moves.
 assumes the bench calls its tasks from one process, one at a time.
*/
`timescale 1ns/10ps
`default_nettype none
`include "deac_cfg.svh"
module deac_cpu_model (
    input wire logic clk_i,
    output logic int_req_o,
    output logic int_wr_o,
    output logic int_ind_o,
    output logic [7:0] int_addr_o,
    output logic [7:0] int_wdata_o,
    input wire logic [7:0] int_rdata_i,
    output logic xm_req_o,
    output logic xm_wr_o,
    output logic [7:0] xm_wdata_o
);
    // shadow copy of the store control settings last written
    logic [7:0] ctl_q;

    // idle strobes at time zero; qualifiers stay unknown until first use
    initial begin
        {int_req_o, xm_req_o, ctl_q} = 10'h000;
    end

    // one internal access; released lines show the inverse so stale data never matches
    task automatic acc(input logic w, input logic ind, input logic [7:0] a,
                       input logic [7:0] wd, output logic [7:0] rd);
        @(posedge clk_i);
        #1;
        {int_req_o, int_wr_o, int_ind_o, int_addr_o, int_wdata_o} = {1'b1, w, ind, a, wd};
        @(posedge clk_i);
        #1;
        {int_req_o, int_addr_o, int_wdata_o} = {1'b0, ~a, ~wd};
        rd = int_rdata_i;
    endtask

    // write the store control register and remember it
    task automatic ctl(input logic [7:0] v);
        logic [7:0] rd;
        ctl_q = v;
        acc(1'b1, 1'b0, `DEAC_SFR_STORE, v, rd);
    endtask

    // load one pointer bank, low byte then high byte
    task automatic setp(input logic bank, input logic [15:0] a);
        logic [7:0] rd;
        acc(1'b1, 1'b0, bank ? `DEAC_SFR_PTR1_LO : `DEAC_SFR_PTR0_LO, a[7:0], rd);
        acc(1'b1, 1'b0, bank ? `DEAC_SFR_PTR1_HI : `DEAC_SFR_PTR0_HI, a[15:8], rd);
    endtask

    // external move through the chosen bank; the bank is always selected first
    task automatic move(input logic bank, input logic w, input logic [7:0] d);
        ctl({ctl_q[7:3], bank, ctl_q[1:0]});
        @(posedge clk_i);
        #1;
        {xm_req_o, xm_wr_o, xm_wdata_o} = {1'b1, w, d};
        @(posedge clk_i);
        #1;
        {xm_req_o, xm_wdata_o} = {1'b0, ~d};
    endtask
endmodule // deac_cpu_model
`default_nettype wire

/* File: tb/data_eeprom_access_control_bench.sv */
/*
 self-checking bench for deac_core with a short programming time.
 assumes deac_cpu_model stands in for the cpu core.
*/
`timescale 1ns/10ps
`default_nettype none
`include "deac_cfg.svh"
module data_eeprom_access_control_bench;
    localparam int PROG = 20;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic npor = 1'b0;
    logic supply_ok = 1'b1;
    logic int_req, int_wr, int_ind, xm_req, xm_wr, xm_ack, ext_req, ext_wr, busy;
    logic [7:0] int_addr, int_wdata, int_rdata, xm_wdata, xm_rdata, ext_wdata;
    logic [15:0] ext_addr;
    int num_errors = 0;
    int n_checks = 0;

    // 20 MHz clock
    always #25 clk = ~clk;

    // block under test and the core driving it
    deac_core #(.PROG_CYCLES(PROG)) DUT (.clk_i(clk), .nrst_i(nrst), .npor_i(npor),
        .supply_ok_i(supply_ok), .int_req_i(int_req), .int_wr_i(int_wr),
        .int_indirect_i(int_ind), .int_addr_i(int_addr), .int_wdata_i(int_wdata),
        .int_rdata_o(int_rdata), .xm_req_i(xm_req), .xm_wr_i(xm_wr),
        .xm_wdata_i(xm_wdata), .xm_ack_o(xm_ack), .xm_rdata_o(xm_rdata),
        .ext_req_o(ext_req), .ext_wr_o(ext_wr), .ext_addr_o(ext_addr),
        .ext_wdata_o(ext_wdata), .busy_o(busy));
    deac_cpu_model cpu (.clk_i(clk), .int_req_o(int_req), .int_wr_o(int_wr),
        .int_ind_o(int_ind), .int_addr_o(int_addr), .int_wdata_o(int_wdata),
        .int_rdata_i(int_rdata), .xm_req_o(xm_req), .xm_wr_o(xm_wr),
        .xm_wdata_o(xm_wdata));

    // verdict and end of run
    task automatic final_report();
        if (num_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // byte compare
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // address compare
    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // flag compare
    task automatic chkb(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask

    // wait for programming to end, bounded; n is cycles spent busy
    task automatic wait_idle(output int n);
        n = 0;
        @(posedge clk);
        #1;
        while (busy === 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 100) begin
            chkb("busy timeout", 1'b0, busy);
            final_report();
        end
    endtask

    // store cell access through pointer bank zero
    task automatic cell_wr(input logic [15:0] a, input logic [7:0] v);
        cpu.setp(1'b0, a);
        cpu.move(1'b0, 1'b1, v);
    endtask
    task automatic cell_rd(input logic [15:0] a, output logic [7:0] d);
        cpu.setp(1'b0, a);
        cpu.move(1'b0, 1'b0, 8'h00);
        d = xm_rdata;
    endtask

    // register values after power-up and reset
    task automatic t_reset();
        logic [7:0] d;
        cpu.acc(1'b0, 1'b0, `DEAC_SFR_STORE, 8'h00, d);
        chk8("store control", 8'h03, d);
        for (int k = 0; k < 4; k++) begin
            cpu.acc(1'b0, 1'b0, 8'h82 + 8'(k), 8'h00, d);
            chk8("pointer byte", 8'h00, d);
        end
        cpu.acc(1'b0, 1'b0, `DEAC_SFR_PWR, 8'h00, d);
        chk8("power control", 8'h10, d);
    endtask

    // both banks hold values and the select bit steers moves
    task automatic t_pointers();
        logic [7:0] d;
        cpu.setp(1'b0, 16'h0211);
        cpu.setp(1'b1, 16'h1234);
        cpu.acc(1'b0, 1'b0, `DEAC_SFR_PTR1_HI, 8'h00, d);
        chk8("bank one high", 8'h12, d);
        cpu.ctl(8'h00);
        cpu.move(1'b0, 1'b0, 8'h00);
        chkb("external request", 1'b1, ext_req);
        chk16("bank zero address", 16'h0211, ext_addr);
        cpu.move(1'b1, 1'b1, 8'h5C);
        chk16("bank one address", 16'h1234, ext_addr);
        chk8("external write data", 8'h5C, ext_wdata);
        chkb("external write", 1'b1, ext_wr);
    endtask

    // upper half: direct reaches registers, indirect reaches ram
    task automatic t_routing();
        logic [7:0] d;
        cpu.acc(1'b1, 1'b1, 8'hA0, 8'h5A, d);
        cpu.acc(1'b1, 1'b0, 8'hA0, 8'hC3, d);
        cpu.acc(1'b0, 1'b1, 8'hA0, 8'h00, d);
        chk8("indirect ram", 8'h5A, d);
        cpu.acc(1'b0, 1'b0, 8'hA0, 8'h00, d);
        chk8("direct unmapped", 8'h00, d);
        cpu.acc(1'b1, 1'b1, `DEAC_SFR_STORE, 8'hFF, d);
        cpu.acc(1'b0, 1'b0, `DEAC_SFR_STORE, 8'h00, d);
        chk8("store control kept", 8'h07, d);
        cpu.acc(1'b0, 1'b1, `DEAC_SFR_STORE, 8'h00, d);
        chk8("ram behind store control", 8'hFF, d);
    endtask

    // on-chip store only below 2K, checked with the store enabled
    task automatic t_decode();
        cpu.ctl(8'h08);
        cpu.setp(1'b0, 16'h07FF);
        cpu.move(1'b0, 1'b0, 8'h00);
        chkb("move ack", 1'b1, xm_ack);
        chkb("last store address", 1'b0, ext_req);
        cpu.setp(1'b0, 16'h0800);
        cpu.move(1'b0, 1'b0, 8'h00);
        chkb("first external address", 1'b1, ext_req);
        chk16("external address", 16'h0800, ext_addr);
    endtask

    // byte write, busy reads and write enable
    task automatic t_byte();
        logic [7:0] d;
        int n;
        cpu.ctl(8'h18);
        cell_wr(16'h0101, 8'h3C);
        wait_idle(n);
        cell_wr(16'h0100, 8'hA5);
        cpu.acc(1'b0, 1'b0, `DEAC_SFR_STORE, 8'h00, d);
        chkb("ready while busy", 1'b0, d[1]);
        cell_rd(16'h0100, d);
        chk8("busy read", 8'h25, d);
        chkb("busy output", 1'b1, busy);
        wait_idle(n);
        cpu.acc(1'b0, 1'b0, `DEAC_SFR_STORE, 8'h00, d);
        chkb("ready after", 1'b1, d[1]);
        cell_rd(16'h0100, d);
        chk8("written byte", 8'hA5, d);
        cell_rd(16'h0101, d);
        chk8("neighbour byte", 8'h3C, d);
        cpu.ctl(8'h08);
        cell_wr(16'h0100, 8'h99);
        @(posedge clk);
        #1;
        chkb("busy without enable", 1'b0, busy);
        cell_rd(16'h0100, d);
        chk8("byte without enable", 8'hA5, d);
    endtask

    // page load, one programming cycle, buffer emptied afterwards
    task automatic t_page();
        logic [7:0] d;
        int n;
        cpu.ctl(8'h18);
        cell_wr(16'h0081, 8'h11);
        wait_idle(n);
        cpu.ctl(8'h38);
        for (int k = 0; k < 3; k++) begin
            cell_wr(16'h0040 + 16'(k), 8'hB0 + 8'(k));
        end
        cpu.acc(1'b0, 1'b0, `DEAC_SFR_STORE, 8'h00, d);
        chkb("ready during load", 1'b1, d[1]);
        cpu.ctl(8'h18);
        cell_wr(16'h0043, 8'hB3);
        wait_idle(n);
        chkb("program time", 1'b1, n >= PROG - 2 && n <= PROG + 1);
        for (int k = 0; k < 4; k++) begin
            cell_rd(16'h0040 + 16'(k), d);
            chk8("page byte", 8'hB0 + 8'(k), d);
        end
        cell_wr(16'h0080, 8'h22);
        wait_idle(n);
        cell_rd(16'h0081, d);
        chk8("no stale slot", 8'h11, d);
    endtask

    // low supply aborts and blocks programming
    task automatic t_inhibit();
        logic [7:0] d;
        int n;
        cpu.ctl(8'h18);
        cell_wr(16'h0200, 8'h33);
        wait_idle(n);
        cell_wr(16'h0200, 8'h77);
        supply_ok = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chkb("busy after abort", 1'b0, busy);
        cpu.acc(1'b0, 1'b0, `DEAC_SFR_STORE, 8'h00, d);
        chk8("store control low supply", 8'h1A, d);
        cell_wr(16'h0200, 8'h55);
        @(posedge clk);
        #1;
        chkb("busy while inhibited", 1'b0, busy);
        supply_ok = 1'b1;
        cell_rd(16'h0200, d);
        chk8("cell after abort", 8'h33, d);
    endtask

    // power loss flag is writable and survives a warm reset
    task automatic t_power();
        logic [7:0] d;
        cpu.acc(1'b1, 1'b0, `DEAC_SFR_PWR, 8'h00, d);
        nrst = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        nrst = 1'b1;
        cpu.acc(1'b0, 1'b0, `DEAC_SFR_PWR, 8'h00, d);
        chk8("flag after reset", 8'h00, d);
        cpu.acc(1'b1, 1'b0, `DEAC_SFR_PWR, 8'hFF, d);
        cpu.acc(1'b0, 1'b0, `DEAC_SFR_PWR, 8'h00, d);
        chk8("flag set", 8'h10, d);
    endtask

    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        #1;
        nrst = 1'b1;
        npor = 1'b1;
        t_reset();
        t_pointers();
        t_routing();
        t_decode();
        t_byte();
        t_page();
        t_inhibit();
        t_power();
        final_report();
    end
endmodule // data_eeprom_access_control_bench
`default_nettype wire
